// ==== verilog/motor_ctrl_pkg.sv ====
// constants and types for the h-bridge current control block
package motor_ctrl_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CUR_W = 16;
  localparam int unsigned CMD_W = 8;
  localparam logic signed [CMD_W-1:0] CMD_MIN = -8'sd100;
  localparam logic signed [CMD_W-1:0] CMD_MAX = 8'sd100;
  localparam logic signed [8:0] CMD_SPAN = 9'sd200;
  localparam logic [CUR_W-1:0] PEAK_HI_MA = 16'd300;
  localparam logic [CUR_W-1:0] PEAK_MID_MA = 16'd270;
  localparam logic [CUR_W-1:0] HW_TRIP_A = 16'd350;
  localparam int unsigned PEAK_HI_MS = 25;
  localparam int unsigned PEAK_MID_MS = 250;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned PEAK_HI_CYC = PEAK_HI_MS * CYC_PER_MS;
  localparam int unsigned PEAK_MID_CYC = PEAK_MID_MS * CYC_PER_MS;
  localparam int unsigned MS_W = 18;
  localparam logic [1:0] COMBO_OFF = 2'h0;
  localparam logic [1:0] COMBO_FWD = 2'h1;
  localparam logic [1:0] COMBO_REV = 2'h2;
  localparam logic [3:0] FILT_W = 4'd15;
  typedef enum logic [1:0] {
    BRIDGE_OFF,
    BRIDGE_BRAKE,
    BRIDGE_FWD,
    BRIDGE_REV
  } bridge_t;
endpackage : motor_ctrl_pkg

// ==== verilog/peak_mask_timer.sv ====
// masking timer for one over-current peak threshold
`timescale 1ns/1ps
module peak_mask_timer
  import motor_ctrl_pkg::*;
#(
  parameter int unsigned LIMIT_CYC = 1000
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic above_in,
  output logic expired_out
);
  logic [31:0] count_reg;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_reg <= 32'h0;
    end else if (!above_in) begin
      count_reg <= 32'h0;
    end else if (count_reg < LIMIT_CYC) begin
      count_reg <= count_reg + 32'h1;
    end
  end

  assign expired_out = above_in && (count_reg >= LIMIT_CYC);
endmodule : peak_mask_timer

// ==== verilog/h_bridge_motor_current_control.sv ====
// h-bridge motor current target, ramp, direction and protection logic
// Contract
// - command -100/+100 map to min/max currents
// - output current clamped within configured limits
// - normal command from selected control source
// - active override replaces normal command
// - override target is limited too
// - override sign selects drive direction
// - ramp up and down at configured durations
// - enable stop cuts drive immediately, no ramp
// - zero is one state, positive the other
// - invert option reverses motor direction
// - over-temperature cutout with hysteresis release
// - filter measured current by configurable constant
// - new direction after N stable signs
// - dead time grounds both motor terminals
// - combined value 0 off 1 fwd 2 rev
// - mask peaks over 300A for 25ms
// - mask peaks over 270A for 250ms
// - after masking hardware trips at 350A
`timescale 1ns/1ps
module h_bridge_motor_current_control
  import motor_ctrl_pkg::*;
#(
  parameter int unsigned PEAK_HI_LIMIT = PEAK_HI_CYC,
  parameter int unsigned PEAK_MID_LIMIT = PEAK_MID_CYC
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic signed [CMD_W-1:0] control_value_in,
  input wire logic signed [CUR_W-1:0] min_cmd_current_in,
  input wire logic signed [CUR_W-1:0] max_cmd_current_in,
  input wire logic override_active_in,
  input wire logic signed [CUR_W-1:0] override_current_in,
  input wire logic direction_used_in,
  input wire logic [CMD_W-1:0] direction_value_in,
  input wire logic enable_from_network_in,
  input wire logic [CMD_W-1:0] enable_value_in,
  input wire logic invert_direction_in,
  input wire logic [MS_W-1:0] ramp_up_step_cycles_in,
  input wire logic [MS_W-1:0] ramp_down_step_cycles_in,
  input wire logic [CUR_W-1:0] fet_temp_in,
  input wire logic [CUR_W-1:0] fet_temp_max_in,
  input wire logic [CUR_W-1:0] fet_temp_hyst_in,
  input wire logic [3:0] current_filter_shift_in,
  input wire logic [CUR_W-1:0] motor_current_amps_in,
  input wire logic [7:0] stable_count_in,
  input wire logic [1:0] safe_torque_off_inputs_in,
  output logic [CUR_W-1:0] current_target_out,
  output logic [CUR_W-1:0] filtered_current_out,
  output logic high_side_a_out,
  output logic low_side_a_out,
  output logic high_side_b_out,
  output logic low_side_b_out,
  output logic drive_disable_out,
  output logic over_temp_out,
  output logic over_current_out
);
  logic signed [9:0] cmd_off;
  logic signed [CUR_W:0] cur_diff;
  logic signed [CUR_W+9:0] span_prod;
  logic signed [CUR_W+9:0] span_quot;
  logic signed [CUR_W-1:0] interp_cur;
  logic signed [CUR_W-1:0] lo_lim;
  logic signed [CUR_W-1:0] hi_lim;
  logic signed [CUR_W-1:0] raw_target;
  logic signed [CUR_W-1:0] clamped;
  logic signed [CUR_W-1:0] ramp_reg;
  logic [MS_W-1:0] ramp_tick_reg;
  logic cmd_neg;
  logic want_rev;
  logic want_enable;
  logic prev_rev_reg;
  logic [7:0] stable_reg;
  logic applied_rev_reg;
  logic dead_reg;
  logic over_temp_reg;
  logic [CUR_W+15:0] filt_acc_reg;
  logic peak_hi_exp;
  logic peak_mid_exp;
  logic hw_enable;
  bridge_t bridge_state;
  logic [CUR_W-1:0] mag;
  logic above_hi;
  logic above_mid;
  logic sto_released;

  // linear map of -100..100 to min..max currents
  assign cmd_off = 10'(control_value_in) - 10'(CMD_MIN);
  assign cur_diff = 17'(max_cmd_current_in) - 17'(min_cmd_current_in);
  assign span_prod = 26'(cmd_off) * 26'(cur_diff);
  assign span_quot = span_prod / 26'(CMD_SPAN);
  assign interp_cur = CUR_W'(min_cmd_current_in + CUR_W'(span_quot));
  assign lo_lim = (min_cmd_current_in < max_cmd_current_in) ? min_cmd_current_in
                  : max_cmd_current_in;
  assign hi_lim = (min_cmd_current_in < max_cmd_current_in) ? max_cmd_current_in
                  : min_cmd_current_in;

  always_comb begin
    if (override_active_in) begin
      raw_target = override_current_in;
    end else if (control_value_in > CMD_MAX) begin
      raw_target = max_cmd_current_in;
    end else if (control_value_in < CMD_MIN) begin
      raw_target = min_cmd_current_in;
    end else begin
      raw_target = interp_cur;
    end
    if (raw_target > hi_lim) begin
      clamped = hi_lim;
    end else if (raw_target < lo_lim) begin
      clamped = lo_lim;
    end else begin
      clamped = raw_target;
    end
  end

  // direction and enable decoding
  always_comb begin
    cmd_neg = clamped < 0;
    // combined network value, reserved codes disable
    if (!direction_used_in && enable_from_network_in) begin
      case (enable_value_in)
        8'(COMBO_FWD): begin
          want_enable = 1'b1;
          want_rev = 1'b0;
        end
        8'(COMBO_REV): begin
          want_enable = 1'b1;
          want_rev = 1'b1;
        end
        default: begin
          want_enable = 1'b0;
          want_rev = 1'b0;
        end
      endcase
    end else begin
      // separate direction and enable sources
      want_enable = enable_value_in != 8'h00;
      want_rev = direction_used_in ? (direction_value_in != 8'h00) : cmd_neg;
    end
    if (override_active_in) begin
      want_rev = cmd_neg;
    end
    want_rev = want_rev ^ invert_direction_in;
  end

  // stable sign counting before direction change
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev_rev_reg <= 1'b0;
      stable_reg <= 8'h00;
      applied_rev_reg <= 1'b0;
      dead_reg <= 1'b0;
    end else begin
      prev_rev_reg <= want_rev;
      if (want_rev != prev_rev_reg) begin
        stable_reg <= 8'h01;
      end else if (stable_reg != 8'hff) begin
        stable_reg <= stable_reg + 8'h01;
      end
      if (want_rev != applied_rev_reg) begin
        dead_reg <= 1'b1;
        if (want_rev == prev_rev_reg && stable_reg >= stable_count_in) begin
          applied_rev_reg <= want_rev;
          dead_reg <= 1'b0;
        end
      end else begin
        dead_reg <= 1'b0;
      end
    end
  end

  // temperature cutout with hysteresis
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      over_temp_reg <= 1'b0;
    end else if (fet_temp_in > fet_temp_max_in) begin
      over_temp_reg <= 1'b1;
    end else if (32'(fet_temp_in) + 32'(fet_temp_hyst_in) < 32'(fet_temp_max_in)) begin
      over_temp_reg <= 1'b0;
    end
  end

  // measured current filter: acc += (in - acc) >> k
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      filt_acc_reg <= '0;
    end else begin
      filt_acc_reg <= 32'(filt_acc_reg + ((32'(motor_current_amps_in) << 16) >>
                      current_filter_shift_in) - (filt_acc_reg >>
                      current_filter_shift_in));
    end
  end
  assign filtered_current_out = filt_acc_reg[CUR_W+15:16];

  // drive allowed only with enable, cool fets and safety released
  assign sto_released = safe_torque_off_inputs_in == 2'b00;
  assign hw_enable = want_enable && !over_temp_reg && sto_released;
  // current magnitude for the ramp
  assign mag = clamped < 0 ? CUR_W'(-clamped) : CUR_W'(clamped);

  // ramp toward target, cut at once on disable
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ramp_reg <= '0;
      ramp_tick_reg <= '0;
    end else if (!hw_enable || dead_reg) begin
      ramp_reg <= '0;
      ramp_tick_reg <= '0;
    end else begin
      if (ramp_reg < signed'(mag)) begin
        if (ramp_tick_reg >= ramp_up_step_cycles_in) begin
          ramp_reg <= ramp_reg + 16'sd1;
          ramp_tick_reg <= '0;
        end else begin
          ramp_tick_reg <= ramp_tick_reg + 18'h1;
        end
      end else if (ramp_reg > signed'(mag)) begin
        if (ramp_tick_reg >= ramp_down_step_cycles_in) begin
          ramp_reg <= ramp_reg - 16'sd1;
          ramp_tick_reg <= '0;
        end else begin
          ramp_tick_reg <= ramp_tick_reg + 18'h1;
        end
      end else begin
        ramp_tick_reg <= '0;
      end
    end
  end
  assign current_target_out = CUR_W'(ramp_reg);

  // peak comparators feeding the masking timers
  assign above_hi = motor_current_amps_in > PEAK_HI_MA;
  assign above_mid = motor_current_amps_in > PEAK_MID_MA;
  peak_mask_timer #(.LIMIT_CYC(PEAK_HI_LIMIT)) u_peak_hi (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .above_in(above_hi),
    .expired_out(peak_hi_exp)
  );
  peak_mask_timer #(.LIMIT_CYC(PEAK_MID_LIMIT)) u_peak_mid (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .above_in(above_mid),
    .expired_out(peak_mid_exp)
  );

  // hardware detector armed after masking expires
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      over_current_out <= 1'b0;
    end else begin
      over_current_out <= (peak_hi_exp || peak_mid_exp) &&
                          (motor_current_amps_in >= HW_TRIP_A);
    end
  end

  // bridge state from enable, dead time and direction
  always_comb begin
    if (!hw_enable) begin
      bridge_state = BRIDGE_OFF;
    end else if (dead_reg) begin
      bridge_state = BRIDGE_BRAKE;
    end else if (applied_rev_reg) begin
      bridge_state = BRIDGE_REV;
    end else begin
      bridge_state = BRIDGE_FWD;
    end
  end

  // registered gate drive
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      high_side_a_out <= 1'b0;
      low_side_a_out <= 1'b0;
      high_side_b_out <= 1'b0;
      low_side_b_out <= 1'b0;
      drive_disable_out <= 1'b1;
    end else begin
      drive_disable_out <= !hw_enable;
      unique case (bridge_state)
        BRIDGE_OFF: begin
          {high_side_a_out, low_side_a_out, high_side_b_out, low_side_b_out} <= 4'h0;
        end
        BRIDGE_BRAKE: begin
          {high_side_a_out, low_side_a_out, high_side_b_out, low_side_b_out} <= 4'h5;
        end
        BRIDGE_FWD: begin
          {high_side_a_out, low_side_a_out, high_side_b_out, low_side_b_out} <= 4'h9;
        end
        BRIDGE_REV: begin
          {high_side_a_out, low_side_a_out, high_side_b_out, low_side_b_out} <= 4'h6;
        end
      endcase
    end
  end

  // thermal cutout flag
  assign over_temp_out = over_temp_reg;
endmodule : h_bridge_motor_current_control

// ==== bench/motor_chk_assertions.sv ====
// port-level assertions for the h-bridge current control block
`timescale 1ns/1ps
module motor_chk
  import motor_ctrl_pkg::*;
#(
  parameter int unsigned PEAK_HI_LIMIT = 50
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [CMD_W-1:0] enable_value_in,
  input wire logic [1:0] safe_torque_off_inputs_in,
  input wire logic [CUR_W-1:0] fet_temp_in,
  input wire logic [CUR_W-1:0] fet_temp_max_in,
  input wire logic [CUR_W-1:0] fet_temp_hyst_in,
  input wire logic [CUR_W-1:0] motor_current_amps_in,
  input wire logic [CUR_W-1:0] current_target_out,
  input wire logic high_side_a_out,
  input wire logic low_side_a_out,
  input wire logic high_side_b_out,
  input wire logic low_side_b_out,
  input wire logic drive_disable_out,
  input wire logic over_temp_out,
  input wire logic over_current_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // cycles in a row with current at or above the lower peak level
  logic [31:0] run_reg;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) run_reg <= '0;
    else run_reg <= (motor_current_amps_in >= PEAK_MID_MA) ? run_reg + 32'h1 : '0;
  end
  property p_sto_off;
    safe_torque_off_inputs_in != 2'h0 |=> drive_disable_out && current_target_out == 16'h0;
  endproperty
  a_sto_off: assert property (p_sto_off) else $error("drive kept with safety input high");
  property p_en_off;
    enable_value_in == 8'h0 |=> drive_disable_out;
  endproperty
  a_en_off: assert property (p_en_off) else $error("drive not cut on enable off");
  property p_temp_set;
    fet_temp_in > fet_temp_max_in |=> over_temp_out;
  endproperty
  a_temp_set: assert property (p_temp_set) else $error("over temperature not flagged");
  property p_temp_hold;
    over_temp_out && ({1'b0, fet_temp_in} + fet_temp_hyst_in >= {1'b0, fet_temp_max_in})
      |=> over_temp_out;
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("over temperature left early");
  property p_dead;
    high_side_a_out && low_side_b_out |=> !(low_side_a_out && high_side_b_out);
  endproperty
  a_dead: assert property (p_dead) else $error("reversal without dead time");
  property p_trip;
    over_current_out |-> $past(motor_current_amps_in) >= HW_TRIP_A;
  endproperty
  a_trip: assert property (p_trip) else $error("over current below trip level");
  property p_mask;
    over_current_out |-> $past(run_reg) >= PEAK_HI_LIMIT - 1;
  endproperty
  a_mask: assert property (p_mask) else $error("peak not masked long enough");
  property p_ramp;
    current_target_out != 16'h0 |->
      (current_target_out - $past(current_target_out)) inside {16'h0, 16'h1, 16'hffff};
  endproperty
  a_ramp: assert property (p_ramp) else $error("current target jumped");
endmodule : motor_chk
bind h_bridge_motor_current_control motor_chk #(.PEAK_HI_LIMIT(PEAK_HI_LIMIT)) motor_chk_i (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .enable_value_in(enable_value_in),
  .safe_torque_off_inputs_in(safe_torque_off_inputs_in), .fet_temp_in(fet_temp_in),
  .fet_temp_max_in(fet_temp_max_in), .fet_temp_hyst_in(fet_temp_hyst_in),
  .motor_current_amps_in(motor_current_amps_in), .current_target_out(current_target_out),
  .high_side_a_out(high_side_a_out), .low_side_a_out(low_side_a_out),
  .high_side_b_out(high_side_b_out), .low_side_b_out(low_side_b_out),
  .drive_disable_out(drive_disable_out), .over_temp_out(over_temp_out),
  .over_current_out(over_current_out));

// ==== bench/bridge_model.sv ====
// power stage and motor: load current flows only while driven
`timescale 1ns/1ps
module bridge_model (
  input wire logic high_side_a_in,
  input wire logic low_side_a_in,
  input wire logic high_side_b_in,
  input wire logic low_side_b_in,
  input wire logic disable_in,
  input wire logic [15:0] load_amps_in,
  output logic [15:0] motor_current_amps_out
);
  // brake grounds both terminals, no current; shoot-through on side a reads full scale, on side b reads zero
  assign motor_current_amps_out = (high_side_a_in && low_side_a_in) ? 16'hffff :
    (!disable_in && ((high_side_a_in && low_side_b_in) || (low_side_a_in && high_side_b_in)))
    ? load_amps_in : 16'h0;
endmodule : bridge_model

// ==== bench/tb_top.sv ====
// self-checking bench for the h-bridge current control block
`timescale 1ns/1ps
module tb_top;
  import motor_ctrl_pkg::*;
  logic clk, rst, ov_on, dir_used, en_net, inv, ha, la, hb, lb, dis, otemp, ocur;
  logic signed [7:0] cmd;
  logic [7:0] dir_val, en_val, stab;
  logic signed [15:0] mn, mx, ov_cur;
  logic [17:0] rup, rdn;
  logic [15:0] temp, tmax, thyst, amps, load, tgt, filt;
  logic [3:0] fshift;
  logic [1:0] safe_torque_off_inputs;
  int num_errors, n_checks, cnt, v;
  logic [15:0] gexp [3] = '{16'h0, 16'h9, 16'h6};
  wire [15:0] gates = {12'h0, ha, la, hb, lb};
  h_bridge_motor_current_control #(.PEAK_HI_LIMIT(50), .PEAK_MID_LIMIT(100))
    h_bridge_motor_current_control_i (.clock_in(clk), .sys_rst_in(rst),
    .control_value_in(cmd), .min_cmd_current_in(mn), .max_cmd_current_in(mx),
    .override_active_in(ov_on), .override_current_in(ov_cur), .direction_used_in(dir_used),
    .direction_value_in(dir_val), .enable_from_network_in(en_net), .enable_value_in(en_val),
    .invert_direction_in(inv), .ramp_up_step_cycles_in(rup), .ramp_down_step_cycles_in(rdn),
    .fet_temp_in(temp), .fet_temp_max_in(tmax), .fet_temp_hyst_in(thyst),
    .current_filter_shift_in(fshift), .motor_current_amps_in(amps), .stable_count_in(stab),
    .safe_torque_off_inputs_in(safe_torque_off_inputs), .current_target_out(tgt), .filtered_current_out(filt),
    .high_side_a_out(ha), .low_side_a_out(la), .high_side_b_out(hb), .low_side_b_out(lb),
    .drive_disable_out(dis), .over_temp_out(otemp), .over_current_out(ocur));
  bridge_model bridge_model_i (.high_side_a_in(ha), .low_side_a_in(la), .high_side_b_in(hb),
    .low_side_b_in(lb), .disable_in(dis), .load_amps_in(load), .motor_current_amps_out(amps));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cnt++;
    if (cnt == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1; cmd = 8'sh0; mn = -16'sh14; mx = 16'sh14; ov_on = 1'b0; ov_cur = 16'sh0;
    dir_used = 1'b1; dir_val = 8'h0; en_net = 1'b0; en_val = 8'h1; inv = 1'b0; rup = 18'h0;
    rdn = 18'h0; temp = 16'h14; tmax = 16'h64; thyst = 16'ha; fshift = 4'h0; stab = 8'h3;
    safe_torque_off_inputs = 2'h0; load = 16'h0;
    cyc(10);
    rst = 1'b0;
    cmd = 8'sh64; load = 16'h28;
    cyc(30);
    chk("target_max", 16'h14, tgt);
    chk("gates_fwd", 16'h9, gates);
    chk("filt_plain", 16'h28, filt);
    cmd = 8'sh32; fshift = 4'h4; load = 16'hc8;
    cyc(2);
    chk("filt_lag", 16'h1, {15'h0, filt < 16'hc8});
    cyc(30);
    chk("target_half", 16'ha, tgt);
    dir_val = 8'h7;
    cyc(3);
    chk("gates_brake", 16'h5, gates);
    cyc(9);
    chk("gates_rev", 16'h6, gates);
    inv = 1'b1;
    cyc(12);
    chk("gates_inv", 16'h9, gates);
    inv = 1'b0; dir_val = 8'h0; ov_on = 1'b1; ov_cur = -16'sh5;
    cyc(40);
    chk("ovr_target", 16'h5, tgt);
    chk("ovr_rev", 16'h6, gates);
    ov_cur = 16'sh1f4;
    cyc(40);
    chk("ovr_clamp", 16'h14, tgt);
    ov_on = 1'b0; dir_used = 1'b0; en_net = 1'b1;
    for (v = 0; v < 3; v++) begin
      en_val = 8'(v);
      cyc(14);
      chk("combined", gexp[v], gates);
    end
    dir_used = 1'b1; en_net = 1'b0;
    cyc(30);
    en_val = 8'h0;
    cyc(2);
    chk("en_cut", 16'h0, tgt);
    en_val = 8'h1;
    for (v = 1; v < 4; v++) begin
      safe_torque_off_inputs = 2'(v);
      cyc(2);
      chk("sto_off", 16'h1, {15'h0, dis});
    end
    safe_torque_off_inputs = 2'h0; temp = 16'h65;
    cyc(2);
    chk("temp_set", 16'h1, {15'h0, otemp});
    chk("temp_dis", 16'h1, {15'h0, dis});
    temp = 16'h5a;
    cyc(2);
    chk("temp_hold", 16'h1, {15'h0, otemp});
    temp = 16'h59;
    cyc(2);
    chk("temp_clear", 16'h0, {15'h0, otemp});
    cyc(30);
    load = 16'h168;
    cyc(20);
    chk("peak_masked", 16'h0, {15'h0, ocur});
    load = 16'h0;
    cyc(5);
    load = 16'h168;
    cyc(60);
    chk("hw_trip", 16'h1, {15'h0, ocur});
    load = 16'h122;
    cyc(80);
    chk("mid_no_trip", 16'h0, {15'h0, ocur});
    load = 16'h168;
    cyc(2);
    chk("mid_expired_trip", 16'h1, {15'h0, ocur});
    tally_and_finish();
  end
endmodule : tb_top
